/* verilog/safe_state_pkg.sv */
// Package: object indices, codes, reset values and mapping constants
package safe_state_pkg;

  // ==========================================================
  // Object dictionary indices (16-bit index space)
  localparam logic [15:0] IDX_OUTPUT_MAP = 16'h1600;
  localparam logic [15:0] IDX_INPUT_MAP = 16'h1a00;
  localparam logic [15:0] IDX_STATUS_MAP = 16'h1a01;
  localparam logic [15:0] IDX_FALLBACK_MODE = 16'h2100;
  localparam logic [15:0] IDX_FALLBACK_PATTERN = 16'h2102;
  localparam logic [15:0] IDX_FACTORY_RESTORE = 16'h2f00;
  localparam logic [15:0] IDX_INPUT_OBJ = 16'h4000;
  localparam logic [15:0] IDX_STATUS_OBJ = 16'h4001;
  localparam logic [15:0] IDX_OUTPUT_OBJ = 16'h5000;

  // Subindices
  localparam logic [7:0] SUB_COUNT = 8'h00;
  localparam logic [7:0] SUB_ENTRY = 8'h01;

  // ==========================================================
  // Mapping entry fields
  localparam int MAP_IDX_LSB = 16;
  localparam int MAP_SUB_LSB = 8;
  localparam int MAP_LEN_LSB = 0;
  localparam logic [7:0] LEN_OUTPUT = 8'h08;
  localparam logic [7:0] LEN_INPUT = 8'h08;
  localparam logic [7:0] LEN_STATUS = 8'h20;
  localparam logic [7:0] MAP_ENTRY_COUNT = 8'h01;
  localparam int STATUS_BYTES = 4;

  // ==========================================================
  // Network state codes
  localparam logic [3:0] NET_INIT = 4'h1;
  localparam logic [3:0] NET_PREOP = 4'h2;
  localparam logic [3:0] NET_BOOT = 4'h3;
  localparam logic [3:0] NET_SAFEOP = 4'h4;
  localparam logic [3:0] NET_OP = 4'h8;

  // ==========================================================
  // Fallback modes
  localparam logic [7:0] MODE_LOW = 8'h00;
  localparam logic [7:0] MODE_HIGH = 8'h01;
  localparam logic [7:0] MODE_HOLD = 8'h02;
  localparam logic [7:0] MODE_PATTERN = 8'h03;

  // Factory restore request codes
  localparam logic [7:0] RESTORE_NONE = 8'h00;
  localparam logic [7:0] RESTORE_REQ = 8'h01;

  // Reset values
  localparam logic [7:0] RST_MODE = MODE_LOW;
  localparam logic [7:0] RST_PATTERN = 8'h00;
  localparam logic [7:0] RST_RESTORE = RESTORE_NONE;

  // Object access answer codes
  localparam logic [1:0] ANS_OK = 2'h0;
  localparam logic [1:0] ANS_NO_OBJ = 2'h1;
  localparam logic [1:0] ANS_READ_ONLY = 2'h2;
  localparam logic [1:0] ANS_BAD_STATE = 2'h3;

endpackage

/* verilog/process_image_buf.sv */
// Shared process image word store with a single writer and whole-word update
module process_image_buf #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Master side write
  input wire logic m_wr,
  input wire logic [WIDTH-1:0] m_wdata,
  // Device side read
  output logic [WIDTH-1:0] d_rdata,
  output logic fresh
);

  // ==========================================================
  // Storage
  logic [WIDTH-1:0] mem_r, mem_nxt; // Last complete word from master
  logic fresh_r, fresh_nxt; // At least one word received

  // Whole-word update in one edge; reader never sees a half word
  always_comb begin
    mem_nxt = mem_r;
    fresh_nxt = fresh_r;
    if (m_wr) begin
      mem_nxt = m_wdata;
      fresh_nxt = 1'b1;
    end
  end

  // Register stage, read data comes from this flop
  always_ff @(posedge mclk) begin
    if (rst) begin
      mem_r <= '0;
      fresh_r <= 1'b0;
    end else begin
      mem_r <= mem_nxt;
      fresh_r <= fresh_nxt;
    end
  end

  assign d_rdata = mem_r;
  assign fresh = fresh_r;

endmodule

/* verilog/fallback_select.sv */
// Output multiplexer choosing live data or the fallback value of the selected mode (low, high, held or pattern)
module fallback_select #(
  parameter int WIDTH = 8
) (
  // Selection inputs
  input wire logic operational,
  input wire logic [7:0] mode,
  input wire logic [WIDTH-1:0] pattern,
  input wire logic [WIDTH-1:0] live,
  input wire logic [WIDTH-1:0] held,
  // Chosen value
  output logic [WIDTH-1:0] value
);

  // Pure combinational choice; the caller registers the result
  always_comb begin
    if (operational) begin
      value = live;
    end else begin
      unique case (mode)
        safe_state_pkg::MODE_HIGH: value = '1;
        safe_state_pkg::MODE_HOLD: value = held;
        safe_state_pkg::MODE_PATTERN: value = pattern;
        default: value = '0; // Low, also for codes never stored
      endcase
    end
  end

endmodule

/* verilog/output_safe_state_ctrl.sv */
// Output supervision, safe-state objects and mapping descriptors
module output_safe_state_ctrl #(
  parameter int NOUT = 8,
  parameter int NIN = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Network state from the state machine
  input wire logic [3:0] net_state,
  // Mailbox object access request
  input wire logic mbx_req,
  input wire logic mbx_wr,
  input wire logic [15:0] mbx_index,
  input wire logic [7:0] mbx_sub,
  input wire logic [31:0] mbx_wdata,
  // Mailbox answer
  output logic mbx_busy,
  output logic mbx_done,
  output logic [1:0] mbx_status,
  output logic [31:0] mbx_rdata,
  // Cyclic process data
  input wire logic pd_out_wr,
  input wire logic [NOUT-1:0] pd_out_data,
  input wire logic [NIN-1:0] din,
  input wire logic [31:0] io_status,
  output logic [NIN-1:0] pd_in_data,
  output logic [31:0] pd_status_data,
  // Pins and restart interface
  output logic [NOUT-1:0] dout,
  output logic restore_pending,
  input wire logic restart,
  output logic restore_now
);

  // ==========================================================
  // Mailbox engine states
  typedef enum logic [2:0] {
    MB_IDLE = 3'b001,
    MB_EXEC = 3'b010,
    MB_DONE = 3'b100
  } mb_state_t;

  // ==========================================================
  // Declarations
  mb_state_t mb_r, mb_nxt; // Mailbox engine state
  logic wr_r, wr_nxt; // Latched request kind
  logic [15:0] idx_r, idx_nxt; // Latched object index
  logic [7:0] sub_r, sub_nxt; // Latched subindex
  logic [7:0] wval_r, wval_nxt; // Latched write byte
  logic [1:0] ans_r, ans_nxt; // Answer code
  logic [31:0] rdat_r, rdat_nxt; // Read answer data
  logic [7:0] mode_r, mode_nxt; // Fallback mode object
  logic [NOUT-1:0] pat_r, pat_nxt; // Fallback pattern object
  logic [7:0] rest_r, rest_nxt; // Factory restore object
  logic [NOUT-1:0] dout_r, dout_nxt; // Output pins
  logic restore_now_r, restore_now_nxt; // Restart-time restore pulse
  logic busy_r, busy_nxt; // Mailbox busy flag for the port
  logic done_r, done_nxt; // Mailbox answer pulse for the port
  logic pend_r, pend_nxt; // Restore request pending for the port
  logic [NIN-1:0] pin_r; // Sampled inputs for image
  logic [31:0] pst_r; // Sampled status word for image
  logic [NOUT-1:0] live; // Latest master output word
  logic [NOUT-1:0] sel; // Chosen output value
  logic is_op; // Network operational
  logic is_preop; // Writes to safe-state objects allowed
  logic [31:0] map_out, map_in, map_st; // Fixed mapping descriptors

  // ==========================================================
  // Network state decode
  assign is_op = (net_state == safe_state_pkg::NET_OP);
  // Safe-state objects only change in pre-operational, so a running
  // network never sees its fallback swapped under it
  assign is_preop = (net_state == safe_state_pkg::NET_PREOP);

  // Mapping words: index high, subindex middle, length low
  assign map_out = {safe_state_pkg::IDX_OUTPUT_OBJ,
                    safe_state_pkg::SUB_ENTRY,
                    safe_state_pkg::LEN_OUTPUT};
  assign map_in = {safe_state_pkg::IDX_INPUT_OBJ,
                   safe_state_pkg::SUB_ENTRY,
                   safe_state_pkg::LEN_INPUT};
  assign map_st = {safe_state_pkg::IDX_STATUS_OBJ,
                   safe_state_pkg::SUB_ENTRY,
                   safe_state_pkg::LEN_STATUS};

  // ==========================================================
  // Shared output buffer from the master
  process_image_buf #(
    .WIDTH(NOUT)
  ) u_outbuf (
    .mclk(mclk),
    .rst(rst),
    .m_wr(pd_out_wr),
    .m_wdata(pd_out_data),
    .d_rdata(live),
    .fresh()
  );

  // Output value selection
  fallback_select #(
    .WIDTH(NOUT)
  ) u_sel (
    .operational(is_op),
    .mode(mode_r),
    .pattern(pat_r),
    .live(live),
    .held(dout_r),
    .value(sel)
  );

  // ==========================================================
  // Mailbox engine next state; one request runs to its answer
  // before another is accepted, so object writes never interleave
  always_comb begin
    mb_nxt = mb_r;
    wr_nxt = wr_r;
    idx_nxt = idx_r;
    sub_nxt = sub_r;
    wval_nxt = wval_r;
    ans_nxt = ans_r;
    rdat_nxt = rdat_r;
    mode_nxt = mode_r;
    pat_nxt = pat_r;
    rest_nxt = rest_r;
    // Restart consumes a pending restore; a write landing in the
    // same cycle comes later in this process, so the new request wins
    if (restart) begin
      rest_nxt = safe_state_pkg::RST_RESTORE;
    end
    unique case (mb_r)
      MB_IDLE: begin
        // Latch the whole request; later bus changes cannot disturb it
        if (mbx_req) begin
          wr_nxt = mbx_wr;
          idx_nxt = mbx_index;
          sub_nxt = mbx_sub;
          wval_nxt = mbx_wdata[7:0];
          mb_nxt = MB_EXEC;
        end
      end
      MB_EXEC: begin
        // Decode and answer in a single cycle
        ans_nxt = safe_state_pkg::ANS_OK;
        rdat_nxt = '0;
        mb_nxt = MB_DONE;
        unique case (idx_r)
          // Fixed mapping descriptors refuse every write
          safe_state_pkg::IDX_OUTPUT_MAP,
          safe_state_pkg::IDX_INPUT_MAP,
          safe_state_pkg::IDX_STATUS_MAP: begin
            if (wr_r) begin
              ans_nxt = safe_state_pkg::ANS_READ_ONLY;
            end else if (sub_r == safe_state_pkg::SUB_COUNT) begin
              rdat_nxt = {24'h0, safe_state_pkg::MAP_ENTRY_COUNT};
            end else if (sub_r != safe_state_pkg::SUB_ENTRY) begin
              ans_nxt = safe_state_pkg::ANS_NO_OBJ;
            end else if (idx_r == safe_state_pkg::IDX_OUTPUT_MAP) begin
              rdat_nxt = map_out;
            end else if (idx_r == safe_state_pkg::IDX_INPUT_MAP) begin
              rdat_nxt = map_in;
            end else begin
              rdat_nxt = map_st;
            end
          end
          // Mode object; reads ignore the subindex
          safe_state_pkg::IDX_FALLBACK_MODE: begin
            if (!wr_r) begin
              rdat_nxt = {24'h0, mode_r};
            end else if (!is_preop) begin
              ans_nxt = safe_state_pkg::ANS_BAD_STATE;
            end else if (wval_r > safe_state_pkg::MODE_PATTERN) begin
              ans_nxt = safe_state_pkg::ANS_NO_OBJ; // Unknown mode refused
            end else begin
              mode_nxt = wval_r;
            end
          end
          // Pattern object with its own read-only entry count
          safe_state_pkg::IDX_FALLBACK_PATTERN: begin
            if (sub_r == safe_state_pkg::SUB_COUNT) begin
              if (wr_r) ans_nxt = safe_state_pkg::ANS_READ_ONLY;
              else rdat_nxt = 32'h0000_0001;
            end else if (sub_r != safe_state_pkg::SUB_ENTRY) begin
              ans_nxt = safe_state_pkg::ANS_NO_OBJ;
            end else if (!wr_r) begin
              rdat_nxt = 32'(pat_r);
            end else if (!is_preop) begin
              ans_nxt = safe_state_pkg::ANS_BAD_STATE;
            end else begin
              pat_nxt = wval_r[NOUT-1:0];
            end
          end
          // Restore object; the request waits for the next restart
          safe_state_pkg::IDX_FACTORY_RESTORE: begin
            if (!wr_r) begin
              rdat_nxt = {24'h0, rest_r};
            end else if (wval_r > safe_state_pkg::RESTORE_REQ) begin
              ans_nxt = safe_state_pkg::ANS_NO_OBJ; // Reserved code
            end else begin
              rest_nxt = wval_r; // Only stored here
            end
          end
          // Anything else is not an object of this block
          default: ans_nxt = safe_state_pkg::ANS_NO_OBJ;
        endcase
      end
      // Answer shown for exactly one cycle, then back to idle
      MB_DONE: mb_nxt = MB_IDLE;
      default: mb_nxt = MB_IDLE;
    endcase
    // Handshake flags are registered so the ports come from flops
    busy_nxt = (mb_nxt != MB_IDLE);
    done_nxt = (mb_nxt == MB_DONE);
    pend_nxt = (rest_nxt == safe_state_pkg::RESTORE_REQ);
  end

  // Mailbox and object registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      mb_r <= MB_IDLE;
      wr_r <= 1'b0;
      idx_r <= '0;
      sub_r <= '0;
      wval_r <= '0;
      ans_r <= safe_state_pkg::ANS_OK;
      rdat_r <= '0;
      mode_r <= safe_state_pkg::RST_MODE;
      pat_r <= safe_state_pkg::RST_PATTERN[NOUT-1:0];
      rest_r <= safe_state_pkg::RST_RESTORE;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      pend_r <= 1'b0;
    end else begin
      mb_r <= mb_nxt;
      wr_r <= wr_nxt;
      idx_r <= idx_nxt;
      sub_r <= sub_nxt;
      wval_r <= wval_nxt;
      ans_r <= ans_nxt;
      rdat_r <= rdat_nxt;
      mode_r <= mode_nxt;
      pat_r <= pat_nxt;
      rest_r <= rest_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      pend_r <= pend_nxt;
    end
  end

  // ==========================================================
  // Output pins and restart pulse next values
  always_comb begin
    dout_nxt = sel;
    restore_now_nxt = restart &&
      (rest_r == safe_state_pkg::RESTORE_REQ);
  end

  // Output and input image registers
  // Inputs are taken at one edge, so the image never mixes two samples;
  // pins are not filtered here, a glitch on a pin is passed on
  always_ff @(posedge mclk) begin
    if (rst) begin
      dout_r <= '0; // Safe low out of reset; stays low until operational or a non-low mode is written
      restore_now_r <= 1'b0;
      pin_r <= '0;
      pst_r <= '0;
    end else begin
      dout_r <= dout_nxt;
      restore_now_r <= restore_now_nxt;
      pin_r <= din;
      pst_r <= io_status; // Four-byte status in image
    end
  end

  // ==========================================================
  // Ports straight from flip-flops
  assign dout = dout_r;
  assign restore_now = restore_now_r;
  assign restore_pending = pend_r;
  assign pd_in_data = pin_r;
  assign pd_status_data = pst_r;
  assign mbx_busy = busy_r;
  assign mbx_done = done_r;
  assign mbx_status = ans_r;
  assign mbx_rdata = rdat_r;

endmodule

/* bench/fieldbus_master_model.sv */
// Behavioural fieldbus master writing the cyclic output word
module fieldbus_master_model #(
  parameter int NOUT = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Traffic control from the bench
  input wire logic cyc_en,
  input wire logic [NOUT-1:0] cyc_val,
  // Buffered output word
  output logic pd_out_wr,
  output logic [NOUT-1:0] pd_out_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick; // Cycle phase of the exchange

  initial begin
    tick = 2'h0;
    pd_out_wr = 1'b0;
    pd_out_data = '0;
  end

  // Whole word in one strobe, every fourth cycle; idle data toggles
  always @(posedge mclk) begin
    tick <= tick + 2'h1;
    pd_out_wr <= cyc_en && !rst && tick == 2'h0;
    pd_out_data <= (cyc_en && tick == 2'h0) ? cyc_val : ~pd_out_data;
  end
endmodule

/* bench/output_safe_state_ctrl_asserts.sv */
// Port timing checker for the safe-state controller
module output_safe_state_ctrl_asserts #(
  parameter int NOUT = 8
) (
  // Clock, reset, network state
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] net_state,
  // Mailbox
  input wire logic mbx_req,
  input wire logic mbx_wr,
  input wire logic [15:0] mbx_index,
  input wire logic [7:0] mbx_sub,
  input wire logic mbx_busy,
  input wire logic mbx_done,
  input wire logic [1:0] mbx_status,
  input wire logic [31:0] mbx_rdata,
  // Process data and restart
  input wire logic pd_out_wr,
  input wire logic [NOUT-1:0] pd_out_data,
  input wire logic [31:0] io_status,
  input wire logic [31:0] pd_status_data,
  input wire logic [NOUT-1:0] dout,
  input wire logic restore_pending,
  input wire logic restart,
  input wire logic restore_now
);
  logic take; // Request accepted this edge
  assign take = mbx_req && !mbx_busy;

  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ==========================================
  // Mailbox
  done_timing_a: assert property (take |=> mbx_busy ##1 mbx_done)
    else $error("answer late");
  done_end_a: assert property (mbx_done |=> !mbx_done && !mbx_busy)
    else $error("answer not closed");
  ro_map_a: assert property (take && mbx_wr && mbx_index == 16'h1600
    |-> ##2 mbx_done && mbx_status == 2'h2) else $error("map written");
  bad_state_a: assert property (take && mbx_wr
    && mbx_index == 16'h2100 && net_state != 4'h2 |-> ##2 mbx_status == 2'h3)
    else $error("mode write outside preop");
  map_read_a: assert property (take && !mbx_wr
    && mbx_index == 16'h1a01 && mbx_sub == 8'h01
    |-> ##2 mbx_rdata == 32'h4001_0120)
    else $error("status map entry wrong");

  // ==========================================
  // Data paths and restart
  status_image_a: assert property (!$past(rst)
    |-> pd_status_data == $past(io_status))
    else $error("status word not copied");
  live_output_a: assert property (pd_out_wr ##1
    (!pd_out_wr && net_state == 4'h8)[*3] |-> dout == $past(pd_out_data, 3))
    else $error("live data not on pins");
  restore_fire_a: assert property (restart && restore_pending
    && !(mbx_busy && !mbx_done) |=> restore_now && !restore_pending)
    else $error("restore not fired");
  restore_cause_a: assert property (restore_now
    |-> $past(restart) && $past(restore_pending)) else $error("stray restore");

  cover property (take && mbx_wr);
  cover property (restore_now);
  cover property (net_state != 4'h8 && pd_out_wr);
endmodule

bind output_safe_state_ctrl output_safe_state_ctrl_asserts #(.NOUT(NOUT))
  output_safe_state_ctrl_asserts_i (.mclk(mclk), .rst(rst),
  .net_state(net_state), .mbx_req(mbx_req), .mbx_wr(mbx_wr),
  .mbx_index(mbx_index), .mbx_sub(mbx_sub), .mbx_busy(mbx_busy),
  .mbx_done(mbx_done), .mbx_status(mbx_status), .mbx_rdata(mbx_rdata),
  .pd_out_wr(pd_out_wr), .pd_out_data(pd_out_data), .io_status(io_status),
  .pd_status_data(pd_status_data), .dout(dout),
  .restore_pending(restore_pending), .restart(restart),
  .restore_now(restore_now));

/* bench/tb_output_safe_state_ctrl.sv */
// Self-checking bench for the safe-state controller
module tb_output_safe_state_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, mbx_req, mbx_wr, mbx_busy, mbx_done, pd_out_wr, cyc_en;
  logic restart, restore_pending, restore_now;
  logic [3:0] net_state;
  logic [15:0] mbx_index;
  logic [7:0] mbx_sub, din, pd_in_data, dout, pd_out_data, cyc_val;
  logic [31:0] mbx_wdata, mbx_rdata, io_status, pd_status_data;
  logic [1:0] mbx_status;
  int fail_count, cmp_count;
  logic [15:0] mi [3] = '{16'h1600, 16'h1a00, 16'h1a01}; // Map objects
  logic [31:0] me [3] = '{32'h5000_0108, 32'h4000_0108, 32'h4001_0120};
  logic [3:0] ns [4] = '{4'h1, 4'h3, 4'h4, 4'h2}; // Fallback states
  logic [7:0] fb [4] = '{8'h00, 8'hff, 8'h3e, 8'ha5}; // Fallback pins

  output_safe_state_ctrl output_safe_state_ctrl_i (.mclk(mclk), .rst(rst),
    .net_state(net_state), .mbx_req(mbx_req), .mbx_wr(mbx_wr),
    .mbx_index(mbx_index), .mbx_sub(mbx_sub), .mbx_wdata(mbx_wdata),
    .mbx_busy(mbx_busy), .mbx_done(mbx_done), .mbx_status(mbx_status),
    .mbx_rdata(mbx_rdata), .pd_out_wr(pd_out_wr), .pd_out_data(pd_out_data),
    .din(din), .io_status(io_status), .pd_in_data(pd_in_data),
    .pd_status_data(pd_status_data), .dout(dout),
    .restore_pending(restore_pending), .restart(restart),
    .restore_now(restore_now));
  fieldbus_master_model fieldbus_master_model_i (.mclk(mclk), .rst(rst),
    .cyc_en(cyc_en), .cyc_val(cyc_val), .pd_out_wr(pd_out_wr),
    .pd_out_data(pd_out_data));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Verdict and end of run
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk_ans(input logic [1:0] st, input logic [31:0] rd, input bit rdc);
    cmp_count++;
    if (mbx_status !== st || (rdc && mbx_rdata !== rd)) begin
      fail_count++;
      $display("MISMATCH %0t answer %h %h", $time, mbx_status, mbx_rdata);
    end
  endtask

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask

  // One object access; waits for the answer pulse, bounded
  task acc(input logic w, input logic [15:0] i, input logic [7:0] s,
           input logic [31:0] d, input logic [1:0] st, input logic [31:0] rd);
    int n;
    @(negedge mclk);
    mbx_req = 1'b1;
    mbx_wr = w;
    mbx_index = i;
    mbx_sub = s;
    mbx_wdata = d;
    @(negedge mclk);
    mbx_req = 1'b0;
    n = 0;
    while (mbx_done !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    if (n == 8) begin
      fail_count++;
      $display("MISMATCH %0t no answer", $time);
    end
    chk_ans(st, rd, !w);
  endtask

  // Watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge mclk);
    fail_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    stop_test;
  end

  initial begin
    {rst, mbx_req, mbx_wr, restart, cyc_en} = 5'h10;
    {mbx_index, mbx_sub, mbx_wdata, din, cyc_val, io_status} = '0;
    net_state = 4'h1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    acc(0, 16'h2100, 8'h00, 0, 2'h0, 32'h0);
    acc(0, 16'h2f00, 8'h00, 0, 2'h0, 32'h0);
    for (int k = 0; k < 3; k++) begin
      acc(0, mi[k], 8'h00, 0, 2'h0, 32'h1);
      acc(0, mi[k], 8'h01, 0, 2'h0, me[k]);
      acc(1, mi[k], 8'h01, 0, 2'h2, 32'h0);
    end
    acc(0, 16'h7777, 8'h00, 0, 2'h1, 32'h0); // Unknown object
    acc(1, 16'h2100, 8'h00, 32'h3, 2'h3, 32'h0);
    net_state = 4'h2;
    acc(1, 16'h2102, 8'h01, 32'ha5, 2'h0, 32'h0);
    acc(1, 16'h2100, 8'h00, 32'h4, 2'h1, 32'h0);
    acc(0, 16'h2102, 8'h01, 0, 2'h0, 32'ha5);
    // Each mode: live data, then a non-operational state
    for (int m = 0; m < 4; m++) begin
      net_state = 4'h2;
      acc(1, 16'h2100, 8'h00, m, 2'h0, 32'h0);
      cyc_val = 8'h3c ^ 8'(m);
      cyc_en = 1'b1;
      net_state = 4'h8;
      repeat (8) @(negedge mclk);
      chk_val(dout, cyc_val);
      cyc_val = 8'h99;
      net_state = ns[m];
      repeat (8) @(negedge mclk);
      chk_val(dout, fb[m]);
    end
    din = 8'h5a;
    io_status = 32'h8000_0021;
    repeat (2) @(negedge mclk);
    chk_val(pd_in_data, 32'h5a);
    chk_val(pd_status_data, 32'h8000_0021);
    acc(1, 16'h2f00, 8'h00, 32'h2, 2'h1, 32'h0);
    chk_val(restore_pending, 32'h0);
    acc(1, 16'h2f00, 8'h00, 32'h1, 2'h0, 32'h0);
    repeat (3) @(negedge mclk);
    chk_val({restore_pending, restore_now}, 32'h2);
    restart = 1'b1;
    @(negedge mclk);
    restart = 1'b0;
    chk_val({restore_pending, restore_now}, 32'h1);
    acc(0, 16'h2f00, 8'h00, 0, 2'h0, 32'h0);
    // Reset in mid-run brings back the defaults
    rst = 1'b1;
    repeat (5) @(negedge mclk);
    rst = 1'b0;
    chk_val(dout, 32'h0);
    acc(0, 16'h2100, 8'h00, 0, 2'h0, 32'h0);
    acc(0, 16'h2102, 8'h01, 0, 2'h0, 32'h0);
    stop_test;
  end
endmodule
